// >>> core/psc_regs.svh
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
// register offsets
`define PSC_CTRL_OFS 8'h00
`define PSC_STAT_OFS 8'h01
`define PSC_BATT_OFS 8'h02
`define PSC_MASK_OFS 8'h03
// control register fields
`define PSC_WD_SR_BIT 0
`define PSC_WD_PC_BIT 1
`define PSC_SW_POWER_CYCLE_REQ_BIT 2
// status register fields
`define PSC_SR_FLAG_BIT 0
`define PSC_PC_FLAG_BIT 1
`define PSC_HOLD_BIT 2
`define PSC_ENIN_BIT 3
`define PSC_TWARN_BIT 4
`define PSC_TSHUT_BIT 5
// battery register fields
`define PSC_THR_LSB 0
`define PSC_BAT_EN_BIT 4
`define PSC_BAT_LOW_BIT 5
// mask register fields
`define PSC_BAT_UNMASK_BIT 0
`define PSC_TH_UNMASK_BIT 1
// reset values
`define PSC_THR_RST 4'h0
`define PSC_SYNC_RST 9'h007
// serial target address
`define PSC_DEV_ADDR 7'h5A
// timing
`define PSC_CLK_HZ 25000000
`define PSC_WDOG_S 4
`define PSC_LONG_PRESS_S 4
`define PSC_SW_POWER_CYCLE_REQ_MS 8
`define PSC_WDOG_CYC (`PSC_WDOG_S * `PSC_CLK_HZ)
`define PSC_LONG_CYC (`PSC_LONG_PRESS_S * `PSC_CLK_HZ)
`define PSC_SW_POWER_CYCLE_REQ_CYC (`PSC_SW_POWER_CYCLE_REQ_MS * (`PSC_CLK_HZ / 1000))
`define PSC_RST_CYC 1000
`define PSC_PCYC_OFF_CYC 2500
`define PSC_BOOT_WIN_CYC 5000
`endif

// >>> core/psc_pkg.sv
`default_nettype none
package psc_pkg;
   // sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_BOOT = 5'h02,
      ST_RUN = 5'h04,
      ST_PCYC = 5'h08,
      ST_SHUT = 5'h10
   } psc_state_e;
   // serial target byte phases, one-hot
   typedef enum logic [4:0] {
      I2_IDLE = 5'h01,
      I2_DEV = 5'h02,
      I2_REG = 5'h04,
      I2_WDAT = 5'h08,
      I2_RDAT = 5'h10
   } psc_i2c_e;
endpackage
`default_nettype wire

// >>> core/psc_i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
module psc_i2c_target
   import psc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // synchronised bus lines
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe_n,
   // register access
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata,
   output logic hit
);
   logic scl_d, sda_d, rise, fall, start, stop;
   logic ack, tx_on, rd_d, byte_end, match;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [7:0] tx;
   psc_i2c_e ph;

   // edge history; 8 samples per 320 ns bus period is ample margin
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // bus conditions
   assign rise = scl && !scl_d;
   assign fall = !scl && scl_d;
   assign start = scl && scl_d && sda_d && !sda;
   assign stop = scl && scl_d && !sda_d && sda;
   assign byte_end = fall && !ack && cnt == 4'h8;
   assign match = sh[7:1] == `PSC_DEV_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // byte framing and phase tracking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ph <= I2_IDLE;
         cnt <= 4'h0;
         ack <= 1'b0;
         tx_on <= 1'b0;
         sh <= 8'h00;
         addr <= 8'h00;
      end else if (start) begin
         ph <= I2_DEV;
         cnt <= 4'h0;
         ack <= 1'b0;
         tx_on <= 1'b0;
      end else if (stop) begin
         ph <= I2_IDLE;
         ack <= 1'b0;
         tx_on <= 1'b0;
      end else if (ph != I2_IDLE) begin
         if (rise && !ack) begin
            sh <= {sh[6:0], sda};
            cnt <= cnt + 4'h1;
         end
         if (fall && ack) begin
            ack <= 1'b0;
            cnt <= 4'h0;
            tx_on <= ph == I2_RDAT;
         end
         if (byte_end) begin
            case (ph)
               I2_DEV: begin
                  if (match) begin
                     ack <= 1'b1;
                     ph <= sh[0] ? I2_RDAT : I2_REG;
                  end else begin
                     ph <= I2_IDLE;
                  end
               end
               I2_REG: begin
                  ack <= 1'b1;
                  addr <= sh;
                  ph <= I2_WDAT;
               end
               I2_WDAT: begin
                  ack <= 1'b1;
               end
               default: begin
                  ph <= I2_IDLE; // one byte out, then wait for stop
                  tx_on <= 1'b0;
               end
            endcase
         end
      end
   end

   // register strobes, one cycle each
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr <= 1'b0;
         rd <= 1'b0;
         rd_d <= 1'b0;
         hit <= 1'b0;
         wdata <= 8'h00;
      end else begin
         wr <= byte_end && ph == I2_WDAT;
         rd <= byte_end && ph == I2_DEV && match && sh[0];
         rd_d <= rd;
         hit <= byte_end && ph == I2_DEV && match;
         if (byte_end) begin
            wdata <= sh;
         end
      end
   end

   // transmit shifter, msb first, moves on falling scl
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx <= 8'hFF;
      end else if (rd_d) begin
         tx <= rdata;
      end else if (fall && tx_on && cnt != 4'h8) begin
         tx <= {tx[6:0], 1'b1};
      end
   end

   // open drain: enable low pulls the line low
   assign sda_oe_n = !(ack || (tx_on && !tx[7]));

   nack_foreign_a: assert property (@(posedge clk)
      disable iff (!rstn)
      byte_end && ph == I2_DEV && !match |=> !ack && ph == I2_IDLE)
      else $error("foreign address was acknowledged");
endmodule
`default_nettype wire

// >>> core/psc_system_control.sv
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
// Contract
// - reset held low until start-up time-out
// - manual press: reset low, then release time-out
// - interrupt low while enabled condition active
// - interrupt sources masked after reset
// - enable-path press starts power-on sequence
// - no hold at release: all regulators off
// - running system stays on while hold high
// - running press reported on button status
// - watchdog runs only when enabled
// - addressed bus transaction restarts watchdog
// - watchdog expiry: soft reset or cycle
// - power-cycle request waits then cycles
// - bus target only, address 1011010
// - serial port works up to 400 kHz
// - single-byte register writes and reads
// - bytes msb first, rising edge, ack
// - battery monitor off until threshold written
// - battery flag one while below threshold
// - battery interrupt only when unmasked
// - thermal warning interrupt when unmasked
// - short press: soft reset, read-clear flag
// - long press: power cycle, read-clear flag
// - button status low while button pressed
// - thermal shutdown locks regulators off
module psc_system_control
   import psc_pkg::*;
#(
   parameter logic [26:0] RST_CYC = 27'(`PSC_RST_CYC),
   parameter logic [26:0] WDOG_CYC = 27'(`PSC_WDOG_CYC),
   parameter logic [26:0] LONG_CYC = 27'(`PSC_LONG_CYC),
   parameter logic [26:0] SW_POWER_CYCLE_REQ_CYC = 27'(`PSC_SW_POWER_CYCLE_REQ_CYC),
   parameter logic [26:0] PCYC_OFF_CYC = 27'(`PSC_PCYC_OFF_CYC),
   parameter logic [26:0] BOOT_WIN_CYC = 27'(`PSC_BOOT_WIN_CYC)
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // serial bus
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N,
   // button and host control
   input wire logic PUSH_BUTTON_IN_N,
   input wire logic MANUAL_RESET_PRESS,
   input wire logic POWER_HOLD_IN,
   input wire logic POWER_ENABLE_IN,
   // analog indications
   input wire logic BATTERY_CMP_LOW,
   input wire logic THERMAL_WARN,
   input wire logic THERMAL_SHUTDOWN,
   // open-drain outputs
   output logic RESET_OUT_N,
   output logic RESET_OUT_OE_N,
   output logic IRQ_OUT_N,
   output logic IRQ_OUT_OE_N,
   output logic BUTTON_STATUS_OUT_N,
   output logic BUTTON_STATUS_OUT_OE_N,
   // analog controls
   output logic REGULATORS_ON,
   output logic BATTERY_MONITOR_EN,
   output logic [3:0] BATTERY_THRESHOLD_SEL
);
   localparam logic [8:0] SYNC_RST = `PSC_SYNC_RST;

   logic [8:0] raw, sync_a, sync_b;
   logic scl_s, sda_s, pb_n_s, mr_s, hold_s, enin_s, bat_s, twarn_s, tshut_s;
   logic [7:0] i2c_addr, i2c_wdata, acc_addr, acc_wdata, rd_val, rdata;
   logic i2c_wr, i2c_rd, i2c_hit, host_acc, acc_wr, acc_rd, rd_stat;
   logic wd_sr_en, wd_pc_en, sw_power_cycle_req_req, bat_en, bat_unmask, th_unmask;
   logic [3:0] thr;
   logic soft_flag, pc_flag, bat_low, mr_d, short_rel, long_hit;
   logic wd_en, wd_exp, wd_soft, wd_pc, sw_power_cycle_req_fire, pcyc_go, pcyc_done;
   logic [26:0] press_cnt, wd_cnt, sw_power_cycle_req_cnt, st_cnt, rst_cnt;
   psc_state_e st, next_st;
   logic auto_boot, regs_on, rst_hold, rst_drive, irq_drive, pb_stat;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, two stages per input
   assign raw = {THERMAL_SHUTDOWN, THERMAL_WARN, BATTERY_CMP_LOW,
                 POWER_ENABLE_IN, POWER_HOLD_IN, MANUAL_RESET_PRESS,
                 PUSH_BUTTON_IN_N, SDA_IN, SCL_IN};
   for (genvar i = 0; i < 9; i++) begin : g_sync
      always_ff @(posedge CLK or negedge RSTN) begin
         if (!RSTN) begin
            sync_a[i] <= SYNC_RST[i];
            sync_b[i] <= SYNC_RST[i];
         end else begin
            sync_a[i] <= raw[i];
            sync_b[i] <= sync_a[i];
         end
      end
   end
   assign {tshut_s, twarn_s, bat_s, enin_s, hold_s, mr_s, pb_n_s,
           sda_s, scl_s} = sync_b;

   ////////////////////////////////////////////////////////////////////////
   // serial target
   psc_i2c_target u_i2c (
      .clk(CLK),
      .rstn(RSTN),
      .scl(scl_s),
      .sda(sda_s),
      .sda_oe_n(SDA_OE_N),
      .addr(i2c_addr),
      .wdata(i2c_wdata),
      .wr(i2c_wr),
      .rd(i2c_rd),
      .rdata(rdata),
      .hit(i2c_hit)
   );
   assign SDA_OUT = 1'b0;

   // register access mux; the plain port wins a same-cycle collision
   assign host_acc = REG_WR | REG_RD;
   assign acc_addr = host_acc ? REG_ADDR : i2c_addr;
   assign acc_wdata = REG_WR ? REG_WDATA : i2c_wdata;
   assign acc_wr = REG_WR | (i2c_wr & !host_acc);
   assign acc_rd = REG_RD | (i2c_rd & !host_acc);
   assign rd_stat = acc_rd && acc_addr == `PSC_STAT_OFS;

   ////////////////////////////////////////////////////////////////////////
   // control register: watchdog enables
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wd_sr_en <= 1'b0;
         wd_pc_en <= 1'b0;
      end else if (acc_wr && acc_addr == `PSC_CTRL_OFS) begin
         wd_sr_en <= acc_wdata[`PSC_WD_SR_BIT];
         wd_pc_en <= acc_wdata[`PSC_WD_PC_BIT];
      end
   end

   // power-cycle request, self clearing; a new write beats the clear
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sw_power_cycle_req_req <= 1'b0;
      end else if (acc_wr && acc_addr == `PSC_CTRL_OFS &&
                   acc_wdata[`PSC_SW_POWER_CYCLE_REQ_BIT]) begin
         sw_power_cycle_req_req <= 1'b1;
      end else if (sw_power_cycle_req_fire || !regs_on) begin
         sw_power_cycle_req_req <= 1'b0;
      end
   end

   // battery threshold; first write turns the comparator on
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         thr <= `PSC_THR_RST;
         bat_en <= 1'b0;
      end else if (acc_wr && acc_addr == `PSC_BATT_OFS) begin
         thr <= acc_wdata[`PSC_THR_LSB +: 4];
         bat_en <= 1'b1;
      end
   end

   // interrupt unmask bits, all masked out of reset
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         bat_unmask <= 1'b0;
         th_unmask <= 1'b0;
      end else if (acc_wr && acc_addr == `PSC_MASK_OFS) begin
         bat_unmask <= acc_wdata[`PSC_BAT_UNMASK_BIT];
         th_unmask <= acc_wdata[`PSC_TH_UNMASK_BIT];
      end
   end

   // event flags; set wins over a read in the same cycle
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         soft_flag <= 1'b0;
         pc_flag <= 1'b0;
      end else begin
         if (short_rel || wd_soft) begin
            soft_flag <= 1'b1;
         end else if (rd_stat) begin
            soft_flag <= 1'b0;
         end
         if (pcyc_done) begin
            pc_flag <= 1'b1;
         end else if (rd_stat) begin
            pc_flag <= 1'b0;
         end
      end
   end

   // read decode
   always_comb begin
      rd_val = 8'h00;
      if (acc_addr == `PSC_CTRL_OFS) begin
         rd_val[`PSC_WD_SR_BIT] = wd_sr_en;
         rd_val[`PSC_WD_PC_BIT] = wd_pc_en;
         rd_val[`PSC_SW_POWER_CYCLE_REQ_BIT] = sw_power_cycle_req_req;
      end else if (acc_addr == `PSC_STAT_OFS) begin
         rd_val[`PSC_SR_FLAG_BIT] = soft_flag;
         rd_val[`PSC_PC_FLAG_BIT] = pc_flag;
         rd_val[`PSC_HOLD_BIT] = hold_s;
         rd_val[`PSC_ENIN_BIT] = enin_s;
         rd_val[`PSC_TWARN_BIT] = twarn_s;
         rd_val[`PSC_TSHUT_BIT] = tshut_s;
      end else if (acc_addr == `PSC_BATT_OFS) begin
         rd_val[`PSC_THR_LSB +: 4] = thr;
         rd_val[`PSC_BAT_EN_BIT] = bat_en;
         rd_val[`PSC_BAT_LOW_BIT] = bat_low;
      end else if (acc_addr == `PSC_MASK_OFS) begin
         rd_val[`PSC_BAT_UNMASK_BIT] = bat_unmask;
         rd_val[`PSC_TH_UNMASK_BIT] = th_unmask;
      end
   end

   // read data only in the cycle after the strobe
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata <= 8'h00;
      end else begin
         rdata <= acc_rd ? rd_val : 8'h00;
      end
   end
   assign REG_RDATA = rdata;

   ////////////////////////////////////////////////////////////////////////
   // manual-reset press timer
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         press_cnt <= 27'h0;
         mr_d <= 1'b0;
      end else begin
         mr_d <= mr_s;
         if (!mr_s) begin
            press_cnt <= 27'h0;
         end else if (press_cnt != LONG_CYC) begin
            press_cnt <= press_cnt + 27'h1;
         end
      end
   end
   assign short_rel = mr_d && !mr_s && press_cnt < LONG_CYC &&
                      st == ST_RUN;
   assign long_hit = mr_s && press_cnt == LONG_CYC - 27'h1 &&
                     st == ST_RUN;

   // watchdog: idle unless an enable is set
   assign wd_en = wd_sr_en | wd_pc_en;
   assign wd_exp = wd_en && st == ST_RUN && !i2c_hit &&
                   wd_cnt == WDOG_CYC - 27'h1;
   assign wd_pc = wd_exp && wd_pc_en;
   assign wd_soft = wd_exp && !wd_pc_en;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wd_cnt <= 27'h0;
      end else if (!wd_en || i2c_hit || st != ST_RUN || wd_exp) begin
         wd_cnt <= 27'h0;
      end else begin
         wd_cnt <= wd_cnt + 27'h1;
      end
   end

   // delay between a software request and the power cycle
   assign sw_power_cycle_req_fire = sw_power_cycle_req_req && st == ST_RUN &&
                      sw_power_cycle_req_cnt == SW_POWER_CYCLE_REQ_CYC - 27'h1;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sw_power_cycle_req_cnt <= 27'h0;
      end else if (!sw_power_cycle_req_req || st != ST_RUN || sw_power_cycle_req_fire) begin
         sw_power_cycle_req_cnt <= 27'h0;
      end else begin
         sw_power_cycle_req_cnt <= sw_power_cycle_req_cnt + 27'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power sequencer
   assign pcyc_go = long_hit | wd_pc | sw_power_cycle_req_fire;
   assign pcyc_done = st == ST_PCYC && st_cnt == PCYC_OFF_CYC - 27'h1;
   always_comb begin
      next_st = st;
      case (st)
         ST_OFF: begin
            if (!pb_n_s && !mr_s) begin
               next_st = ST_BOOT;
            end
         end
         ST_BOOT: begin
            // after an automatic restart the host gets a boot window
            if (pb_n_s && (!auto_boot || st_cnt >= BOOT_WIN_CYC)) begin
               next_st = hold_s ? ST_RUN : ST_OFF;
            end
         end
         ST_RUN: begin
            if (pcyc_go) begin
               next_st = ST_PCYC;
            end else if (!hold_s) begin
               next_st = ST_OFF;
            end
         end
         ST_PCYC: begin
            if (pcyc_done) begin
               next_st = ST_BOOT;
            end
         end
         ST_SHUT: begin
            if (!tshut_s) begin
               next_st = ST_OFF;
            end
         end
         default: begin
            next_st = ST_OFF;
         end
      endcase
      if (tshut_s) begin
         next_st = ST_SHUT;
      end
   end

   // state, time in state and restart marker
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st <= ST_OFF;
         st_cnt <= 27'h0;
         auto_boot <= 1'b0;
      end else begin
         st <= next_st;
         st_cnt <= (next_st != st) ? 27'h0 : st_cnt + 27'h1;
         if (next_st == ST_BOOT && st != ST_BOOT) begin
            auto_boot <= st == ST_PCYC;
         end
      end
   end
   assign regs_on = st == ST_BOOT || st == ST_RUN;
   assign REGULATORS_ON = regs_on;

   ////////////////////////////////////////////////////////////////////////
   // reset output; one counter times both start-up and manual release
   assign rst_hold = !regs_on || mr_s || wd_soft;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_cnt <= 27'h0;
         rst_drive <= 1'b1;
      end else begin
         if (rst_hold) begin
            rst_cnt <= 27'h0;
         end else if (rst_cnt != RST_CYC) begin
            rst_cnt <= rst_cnt + 27'h1;
         end
         rst_drive <= rst_hold || rst_cnt != RST_CYC;
      end
   end

   // interrupt and button status, both level driven
   assign bat_low = bat_en && bat_s;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_drive <= 1'b0;
         pb_stat <= 1'b0;
      end else begin
         irq_drive <= (bat_low && bat_unmask) ||
                      (twarn_s && th_unmask);
         pb_stat <= !pb_n_s;
      end
   end

   // open-drain pins: enable low pulls the pin low
   assign RESET_OUT_N = 1'b0;
   assign RESET_OUT_OE_N = !rst_drive;
   assign IRQ_OUT_N = 1'b0;
   assign IRQ_OUT_OE_N = !irq_drive;
   assign BUTTON_STATUS_OUT_N = 1'b0;
   assign BUTTON_STATUS_OUT_OE_N = !pb_stat;
   assign BATTERY_MONITOR_EN = bat_en;
   assign BATTERY_THRESHOLD_SEL = thr;

   ////////////////////////////////////////////////////////////////////////
   rst_release_a: assert property (
      $fell(rst_drive) |-> $past(rst_cnt) == RST_CYC && $past(regs_on))
      else $error("reset released before time-out");
   mr_reset_a: assert property (
      mr_s |=> rst_drive ##1 !RESET_OUT_OE_N)
      else $error("manual press did not hold reset");
   irq_thermal_a: assert property (
      twarn_s && th_unmask |=> !IRQ_OUT_OE_N)
      else $error("unmasked thermal warning not on interrupt");
   mask_write_a: assert property (
      $changed(bat_unmask) || $changed(th_unmask) |->
         $past(acc_wr && acc_addr == `PSC_MASK_OFS))
      else $error("mask changed without a write");
   boot_abort_a: assert property (
      st == ST_BOOT && pb_n_s && !auto_boot && !hold_s && !tshut_s
         |=> st == ST_OFF && !REGULATORS_ON)
      else $error("boot not aborted without hold");
   run_keep_a: assert property (
      st == ST_RUN && hold_s && !pcyc_go && !tshut_s |=> st == ST_RUN)
      else $error("running system lost power with hold");
   wdog_off_a: assert property (
      !wd_en |=> wd_cnt == 27'h0 && !wd_exp)
      else $error("watchdog counts while disabled");
   wdog_kick_a: assert property (
      i2c_hit |=> wd_cnt == 27'h0)
      else $error("bus transaction did not restart watchdog");
   sw_power_cycle_req_wait_a: assert property (
      sw_power_cycle_req_fire |-> $past(sw_power_cycle_req_req) && sw_power_cycle_req_cnt == SW_POWER_CYCLE_REQ_CYC - 27'h1
         ##1 (st == ST_PCYC || st == ST_SHUT))
      else $error("requested power cycle mistimed");
   bat_flag_a: assert property (
      acc_rd && acc_addr == `PSC_BATT_OFS |=>
         rdata[`PSC_BAT_LOW_BIT] == $past(bat_low))
      else $error("battery flag read wrong");
   btn_status_a: assert property (
      !pb_n_s |=> !BUTTON_STATUS_OUT_OE_N)
      else $error("button status not asserted");
   therm_lock_a: assert property (
      tshut_s |=> !REGULATORS_ON ##1 (tshut_s || st != ST_BOOT))
      else $error("regulators on during thermal shutdown");
endmodule
`default_nettype wire

// >>> testbench/psc_bus_host.sv
`timescale 1ns/1ps
`default_nettype none
module psc_bus_host (
   // clock
   input wire logic clk,
   // bus lines
   input wire logic sda_oe_n,
   output logic scl,
   output logic sda
);
   logic drv = 1'b1;
   // pull-up: low when either side pulls
   assign sda = drv & sda_oe_n;
   initial scl = 1'b1;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // data moves while clock low, read back mid-high
   task automatic bit_io(input logic b, output logic s);
      scl <= 1'b0;
      tick(1);
      drv <= b;
      tick(3);
      scl <= 1'b1;
      tick(2);
      @(negedge clk) s = sda;
      tick(2);
   endtask
   // single-byte write, or read with a repeated start when rw is set
   task automatic xfer(input logic rw, input logic [6:0] a,
                       input logic [7:0] r, d, output int acks,
                       output logic [7:0] q);
      logic [7:0] by [3];
      logic s;
      by = '{{a, 1'b0}, r, rw ? {a, 1'b1} : d};
      acks = 0;
      q = 8'h00;
      tick(1);
      drv <= 1'b0;
      tick(4);
      foreach (by[i]) begin
         // repeated start: data released high, clock up, data falls
         if (rw && i == 2) begin
            scl <= 1'b0;
            tick(1);
            drv <= 1'b1;
            tick(3);
            scl <= 1'b1;
            tick(3);
            drv <= 1'b0;
            tick(4);
         end
         for (int k = 7; k >= 0; k--) bit_io(by[i][k], s);
         bit_io(1'b1, s);
         acks += int'(!s);
      end
      // read byte with the line released, then a not-acknowledge
      if (rw) begin
         for (int k = 7; k >= 0; k--) bit_io(1'b1, q[k]);
         bit_io(1'b1, s);
      end
      // stop: data rises while clock high
      scl <= 1'b0;
      tick(1);
      drv <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(3);
      drv <= 1'b1;
      tick(4);
   endtask
endmodule
`default_nettype wire

// >>> testbench/test_psc_system_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_psc_system_control;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, btn_n = 1, mr = 0, hold = 0;
   logic cmp = 0, warn = 0, tsd = 0, scl, sda, sda_oe_n;
   logic rst_oe_n, irq_oe_n, bs_oe_n, regs, mon_en;
   logic [3:0] thr_sel;
   logic [7:0] addr = 0, wd = 0, rdat, v;
   int n_fail = 0, checked = 0, cyc = 0, acks;
   // short counts keep the run brief
   psc_system_control #(.RST_CYC(27'd20), .WDOG_CYC(27'd1000),
      .LONG_CYC(27'd100), .SW_POWER_CYCLE_REQ_CYC(27'd50), .PCYC_OFF_CYC(27'd20),
      .BOOT_WIN_CYC(27'd40)) DUT (.CLK(clk), .RSTN(rstn),
      .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdat), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(),
      .SDA_OE_N(sda_oe_n), .PUSH_BUTTON_IN_N(btn_n),
      .MANUAL_RESET_PRESS(mr), .POWER_HOLD_IN(hold),
      .POWER_ENABLE_IN(hold), .BATTERY_CMP_LOW(cmp), .THERMAL_WARN(warn),
      .THERMAL_SHUTDOWN(tsd), .RESET_OUT_N(), .RESET_OUT_OE_N(rst_oe_n),
      .IRQ_OUT_N(), .IRQ_OUT_OE_N(irq_oe_n), .BUTTON_STATUS_OUT_N(),
      .BUTTON_STATUS_OUT_OE_N(bs_oe_n), .REGULATORS_ON(regs),
      .BATTERY_MONITOR_EN(mon_en), .BATTERY_THRESHOLD_SEL(thr_sel));
   psc_bus_host host (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
   initial forever #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wreg(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk) d = rdat;
      @(posedge clk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_boot;
      chk("rst", rst_oe_n, 0);
      rreg(8'h03, v);
      chk("mask", v, 0);
      chk("mon", {7'h00, mon_en}, 8'h00);
      btn_n <= 0;
      wt(8);
      chk("regs", regs, 1);
      chk("bstat", bs_oe_n, 0);
      btn_n <= 1;
      wt(8);
      chk("regs", regs, 0);
      btn_n <= 0;
      wt(8);
      hold <= 1;
      wt(10);
      chk("rst", rst_oe_n, 0);
      wt(30);
      chk("rst", rst_oe_n, 1);
      btn_n <= 1;
      wt(8);
      chk("regs", regs, 1);
      chk("bstat", bs_oe_n, 1);
   endtask
   task automatic t_mr;
      mr <= 1;
      btn_n <= 0;
      wt(5);
      chk("rst", rst_oe_n, 0);
      mr <= 0;
      btn_n <= 1;
      wt(15);
      chk("rst", rst_oe_n, 0);
      wt(15);
      chk("rst", rst_oe_n, 1);
      rreg(8'h01, v);
      chk("stat", v, 8'h0D);
      rreg(8'h01, v);
      chk("stat", v, 8'h0C);
      // long press in run: regulators cycle, then a timed restart
      mr <= 1;
      btn_n <= 0;
      wt(110);
      chk("regs", regs, 0);
      mr <= 0;
      btn_n <= 1;
      wt(80);
      chk("regs", regs, 1);
      rreg(8'h01, v);
      chk("stat", v, 8'h0E);
   endtask
   task automatic t_ser_irq;
      host.xfer(1'b0, 7'h5B, 8'h03, 8'h02, acks, v);
      chk("acks", 8'(acks), 0);
      host.xfer(1'b0, 7'h5A, 8'h03, 8'h02, acks, v);
      chk("acks", 8'(acks), 3);
      rreg(8'h03, v);
      chk("mask", v, 8'h02);
      host.xfer(1'b1, 7'h5A, 8'h03, 8'h00, acks, v);
      chk("acks", 8'(acks), 3);
      chk("ser rd", v, 8'h02);
      warn <= 1;
      wt(5);
      chk("irq", irq_oe_n, 0);
      warn <= 0;
      wreg(8'h02, 8'h03);
      cmp <= 1;
      wt(5);
      rreg(8'h02, v);
      chk("batt", v, 8'h33);
      chk("mon", {7'h00, mon_en}, 8'h01);
      chk("thr", {4'h0, thr_sel}, 8'h03);
      chk("irq", irq_oe_n, 1);
      wreg(8'h03, 8'h01);
      wt(5);
      chk("irq", irq_oe_n, 0);
      cmp <= 0;
      wt(5);
      chk("irq", irq_oe_n, 1);
   endtask
   task automatic t_wdog;
      wreg(8'h00, 8'h01);
      wt(700);
      host.xfer(1'b0, 7'h5A, 8'h03, 8'h01, acks, v);
      wt(600);
      rreg(8'h01, v);
      chk("stat", v, 8'h0C);
      for (int i = 0; i < 500 && rst_oe_n; i++) wt(1);
      chk("rst", rst_oe_n, 0);
      wreg(8'h00, 8'h00);
      wt(40);
      rreg(8'h01, v);
      chk("stat", v, 8'h0D);
   endtask
   task automatic t_down;
      wreg(8'h00, 8'h04);
      wt(45);
      chk("regs", regs, 1);
      wt(15);
      chk("regs", regs, 0);
      wt(150);
      chk("regs", regs, 1);
      rreg(8'h01, v);
      chk("stat", v, 8'h0E);
      hold <= 0;
      wt(6);
      chk("regs", regs, 0);
      tsd <= 1;
      btn_n <= 0;
      wt(10);
      chk("regs", regs, 0);
      rreg(8'h01, v);
      chk("stat", v, 8'h20);
      btn_n <= 1;
      tsd <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // hang guard well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out;
      end
   end
   initial begin
      wt(8);
      rstn <= 1;
      wt(2);
      t_boot;
      t_mr;
      t_ser_irq;
      t_wdog;
      t_down;
      close_out;
   end
endmodule
`default_nettype wire
